// file: hdl/kcp_pkg.sv
// Package: register map, field layout and prescaler codes of the kernel clock prescaler
package kcp_pkg;

    // Register byte offsets
    localparam logic [5:0] KCP_OFF_CONTROL_ONE      = 6'h00;
    localparam logic [5:0] KCP_OFF_CONTROL_TWO      = 6'h04;
    localparam logic [5:0] KCP_OFF_CONTROL_THREE    = 6'h08;
    localparam logic [5:0] KCP_OFF_BAUD_RATE        = 6'h0c;
    localparam logic [5:0] KCP_OFF_GUARD_TIME       = 6'h10;
    localparam logic [5:0] KCP_OFF_RECEIVE_TIMEOUT  = 6'h14;
    localparam logic [5:0] KCP_OFF_REQUEST_TRIGGERS = 6'h18;
    localparam logic [5:0] KCP_OFF_STATUS           = 6'h1c;
    localparam logic [5:0] KCP_OFF_FLAG_CLEAR       = 6'h20;
    localparam logic [5:0] KCP_OFF_KERNEL_DIVIDER   = 6'h2c;

    // Field positions and reset values
    localparam int          KCP_ENABLE_BIT   = 0;
    localparam int          KCP_CODE_W       = 4;
    localparam logic [3:0]  KCP_CODE_RESET   = 4'h0;
    localparam logic [3:0]  KCP_CODE_MAX     = 4'hb;
    localparam logic [31:0] KCP_WORD_RESET   = 32'h0000_0000;
    localparam int          KCP_RATIO_W      = 9;
    localparam int          KCP_CNT_W        = 8;

    // AXI4-Lite responses
    localparam logic [1:0]  KCP_RESP_OKAY    = 2'h0;
    localparam logic [1:0]  KCP_RESP_SLVERR  = 2'h2;

    typedef struct packed {
        logic [31:0] data;
        logic [1:0]  resp;
    } kcp_rd_t;

    // Ratio for a 4-bit code; codes above the last defined one act as 256
    function automatic logic [8:0] kcp_ratio(input logic [3:0] code);
        case (code)
            4'h0:    kcp_ratio = 9'h001;
            4'h1:    kcp_ratio = 9'h002;
            4'h2:    kcp_ratio = 9'h004;
            4'h3:    kcp_ratio = 9'h006;
            4'h4:    kcp_ratio = 9'h008;
            4'h5:    kcp_ratio = 9'h00a;
            4'h6:    kcp_ratio = 9'h00c;
            4'h7:    kcp_ratio = 9'h010;
            4'h8:    kcp_ratio = 9'h020;
            4'h9:    kcp_ratio = 9'h040;
            4'ha:    kcp_ratio = 9'h080;
            default: kcp_ratio = 9'h100;
        endcase
    endfunction

endpackage

// file: hdl/kcp_regfile.sv
// Register file: word storage for the plain read/write registers of the port
`timescale 1ns/10ps
module kcp_regfile
    import kcp_pkg::*;
#(
    parameter int DEPTH = 16
) (
    input  wire logic                     REF_CLK,
    input  wire logic                     RST_N,
    input  wire logic                     wr_en,
    input  wire logic [$clog2(DEPTH)-1:0] wr_idx,
    input  wire logic [31:0]              wr_data,
    input  wire logic [3:0]               wr_strb,
    input  wire logic [$clog2(DEPTH)-1:0] rd_idx,
    output logic      [31:0]              rd_data
);

    logic [31:0] mem [DEPTH];

    // ----------------------------------------
    // Storage with byte lanes
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : gen_word
            always_ff @(posedge REF_CLK or negedge RST_N) begin
                if (!RST_N) begin
                    mem[g] <= KCP_WORD_RESET;
                end else if (wr_en && wr_idx == g) begin
                    for (int b = 0; b < 4; b++) begin
                        if (wr_strb[b]) begin
                            mem[g][8*b +: 8] <= wr_data[8*b +: 8];
                        end
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rd_data <= KCP_WORD_RESET;
        end else begin
            rd_data <= mem[rd_idx];
        end
    end

endmodule

// file: hdl/kcp_divider.sv
// Divider: produces a one-cycle tick every ratio input clock cycles
`timescale 1ns/10ps
module kcp_divider
    import kcp_pkg::*;
(
    input  wire logic                   REF_CLK,
    input  wire logic                   RST_N,
    input  wire logic                   run,
    input  wire logic [KCP_RATIO_W-1:0] ratio,
    output logic                        tick
);

    logic [KCP_CNT_W-1:0] count;
    logic [KCP_CNT_W-1:0] last;

    assign last = KCP_CNT_W'(ratio - 9'h001);

    // Counter restarts when the port is off so each enable begins aligned
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            count <= '0;
            tick  <= 1'b0;
        end else if (!run) begin
            count <= '0;
            tick  <= 1'b0;
        end else if (count >= last) begin
            count <= '0;
            tick  <= 1'b1;
        end else begin
            count <= count + 8'h01;
            tick  <= 1'b0;
        end
    end

endmodule

// file: hdl/kcp_top.sv
// Top: kernel clock prescaler of a serial port with its AXI4-Lite register map
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module kcp_top
    import kcp_pkg::*;
(
    input  wire logic        REF_CLK,
    input  wire logic        RST_N,
    input  wire logic [5:0]  AWADDR,
    input  wire logic        AWVALID,
    output logic             AWREADY,
    input  wire logic [31:0] WDATA,
    input  wire logic [3:0]  WSTRB,
    input  wire logic        WVALID,
    output logic             WREADY,
    output logic [1:0]       BRESP,
    output logic             BVALID,
    input  wire logic        BREADY,
    input  wire logic [5:0]  ARADDR,
    input  wire logic        ARVALID,
    output logic             ARREADY,
    output logic [31:0]      RDATA,
    output logic [1:0]       RRESP,
    output logic             RVALID,
    input  wire logic        RREADY,
    output logic             BAUD_TICK_TX,
    output logic             BAUD_TICK_RX
);

    typedef enum logic [1:0] {
        KCP_RD_IDLE = 2'b00,
        KCP_RD_MEM  = 2'b01,
        KCP_RD_RESP = 2'b11
    } kcp_rd_state_t;

    logic [5:0]          aw_addr;
    logic                aw_have;
    logic [31:0]         w_data;
    logic [3:0]          w_strb;
    logic                w_have;
    logic                wr_fire;
    logic [KCP_CODE_W-1:0] divider_code;
    logic [31:0]         control_one;
    logic                port_global_enable;
    logic [KCP_RATIO_W-1:0] ratio;
    logic                tick;
    kcp_rd_state_t       rd_state;
    logic [5:0]          ar_addr;
    kcp_rd_t             rd_word;
    logic [31:0]         mem_rd_data;
    logic                rf_wr_en;
    logic [3:0]          rf_rd_idx;

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    function automatic logic kcp_is_mem(input logic [5:0] a);
        kcp_is_mem = (a == KCP_OFF_CONTROL_ONE) || (a == KCP_OFF_CONTROL_TWO) ||
                     (a == KCP_OFF_CONTROL_THREE) || (a == KCP_OFF_BAUD_RATE) ||
                     (a == KCP_OFF_GUARD_TIME) || (a == KCP_OFF_RECEIVE_TIMEOUT);
    endfunction

    function automatic logic kcp_is_mapped(input logic [5:0] a);
        kcp_is_mapped = kcp_is_mem(a) || (a == KCP_OFF_REQUEST_TRIGGERS) ||
                        (a == KCP_OFF_STATUS) || (a == KCP_OFF_FLAG_CLEAR) ||
                        (a == KCP_OFF_KERNEL_DIVIDER);
    endfunction

    // ----------------------------------------
    // Write channel
    // ----------------------------------------
    assign AWREADY = !aw_have && !BVALID;
    assign WREADY  = !w_have && !BVALID;
    assign wr_fire = aw_have && w_have && !BVALID;

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            aw_have <= 1'b0;
            aw_addr <= '0;
        end else if (AWVALID && AWREADY) begin
            aw_have <= 1'b1;
            aw_addr <= {AWADDR[5:2], 2'b00};
        end else if (wr_fire) begin
            aw_have <= 1'b0;
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            w_have <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
        end else if (WVALID && WREADY) begin
            w_have <= 1'b1;
            w_data <= WDATA;
            w_strb <= WSTRB;
        end else if (wr_fire) begin
            w_have <= 1'b0;
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            BVALID <= 1'b0;
            BRESP  <= KCP_RESP_OKAY;
        end else if (wr_fire) begin
            BVALID <= 1'b1;
            BRESP  <= kcp_is_mapped(aw_addr) ? KCP_RESP_OKAY : KCP_RESP_SLVERR;
        end else if (BREADY) begin
            BVALID <= 1'b0;
        end
    end

    assign rf_wr_en = wr_fire && kcp_is_mem(aw_addr);

    // Shadow of control word so the enable bit is visible without a memory read
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            control_one <= KCP_WORD_RESET;
        end else if (wr_fire && aw_addr == KCP_OFF_CONTROL_ONE) begin
            for (int b = 0; b < 4; b++) begin
                if (w_strb[b]) begin
                    control_one[8*b +: 8] <= w_data[8*b +: 8];
                end
            end
        end
    end

    assign port_global_enable = control_one[KCP_ENABLE_BIT];

    // ----------------------------------------
    // Prescaler register
    // ----------------------------------------
    // reset undivided
    // upper bits dropped, read as zero
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            divider_code <= KCP_CODE_RESET;
        end else if (wr_fire && aw_addr == KCP_OFF_KERNEL_DIVIDER && w_strb[0] && !port_global_enable) begin
            divider_code <= w_data[KCP_CODE_W-1:0];
        end
    end

    // ----------------------------------------
    // Division
    // ----------------------------------------
    // code to ratio
    // codes above max act as 256
    assign ratio = kcp_ratio(divider_code);

    kcp_divider kcp_divider_i (
        .REF_CLK (REF_CLK),
        .RST_N   (RST_N),
        .run     (port_global_enable),
        .ratio   (ratio),
        .tick    (tick)
    );

    assign BAUD_TICK_TX = tick;
    assign BAUD_TICK_RX = tick;

    // ----------------------------------------
    // Read channel
    // ----------------------------------------
    assign ARREADY = (rd_state == KCP_RD_IDLE);

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rd_state <= KCP_RD_IDLE;
            ar_addr  <= '0;
        end else begin
            case (rd_state)
                KCP_RD_IDLE: begin
                    if (ARVALID) begin
                        rd_state <= KCP_RD_MEM;
                        ar_addr  <= {ARADDR[5:2], 2'b00};
                    end
                end
                KCP_RD_MEM:  rd_state <= KCP_RD_RESP;
                KCP_RD_RESP: begin
                    if (RREADY) begin
                        rd_state <= KCP_RD_IDLE;
                    end
                end
                default:     rd_state <= KCP_RD_IDLE;
            endcase
        end
    end

    // Index the memory from the bus address while idle, so its registered
    // output already holds the addressed word when the answer is loaded
    assign rf_rd_idx = (rd_state == KCP_RD_IDLE) ? ARADDR[5:2] : ar_addr[5:2];

    kcp_regfile #(.DEPTH(16)) kcp_regfile_i (
        .REF_CLK (REF_CLK),
        .RST_N   (RST_N),
        .wr_en   (rf_wr_en),
        .wr_idx  (aw_addr[5:2]),
        .wr_data (w_data),
        .wr_strb (w_strb),
        .rd_idx  (rf_rd_idx),
        .rd_data (mem_rd_data)
    );

    always_comb begin
        rd_word.data = '0;
        rd_word.resp = KCP_RESP_OKAY;
        if (kcp_is_mem(ar_addr)) begin
            rd_word.data = mem_rd_data;
        end else if (ar_addr == KCP_OFF_KERNEL_DIVIDER) begin
            rd_word.data = {28'h0000000, divider_code};
        end else if (!kcp_is_mapped(ar_addr)) begin
            rd_word.resp = KCP_RESP_SLVERR;
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            RVALID <= 1'b0;
            RDATA  <= '0;
            RRESP  <= KCP_RESP_OKAY;
        end else if (rd_state == KCP_RD_MEM) begin
            RVALID <= 1'b1;
            RDATA  <= rd_word.data;
            RRESP  <= rd_word.resp;
        end else if (RVALID && RREADY) begin
            RVALID <= 1'b0;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    logic [8:0] gap;
    // Starts at all ones so the first period after enable counts like the rest
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            gap <= 9'h1ff;
        end else if (!port_global_enable) begin
            gap <= 9'h1ff;
        end else if (tick) begin
            gap <= '0;
        end else begin
            gap <= gap + 9'h001;
        end
    end

    AST_LOCKED: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        port_global_enable |=> $stable(divider_code))
        else $error("prescaler changed while port enabled");

    AST_RESET_ZERO: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        $rose(RST_N) |-> divider_code == 4'h0)
        else $error("prescaler not zero after reset");

    AST_RATIO_MAX: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        divider_code > KCP_CODE_MAX |-> ratio == 9'h100)
        else $error("reserved code not treated as 256");

    AST_TICK_SPACING: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        tick && $past(tick) && $stable(port_global_enable) |-> ratio == 9'h001)
        else $error("back to back ticks with ratio above one");

    AST_GAP: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        port_global_enable && $past(port_global_enable) && tick |-> gap == ratio - 9'h001)
        else $error("tick spacing differs from ratio");

    AST_BOTH_GEN: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        BAUD_TICK_TX == BAUD_TICK_RX)
        else $error("generators fed differently");

    sequence s_div_write;
        wr_fire && aw_addr == KCP_OFF_KERNEL_DIVIDER && w_strb[0] && !port_global_enable;
    endsequence

    AST_WRITE_TAKEN: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        s_div_write |=> divider_code == $past(w_data[3:0]))
        else $error("allowed prescaler write lost");

    AST_UPPER_ZERO: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        RVALID && ar_addr == KCP_OFF_KERNEL_DIVIDER |-> RDATA[31:4] == 28'h0000000)
        else $error("prescaler upper bits not zero");

    AST_IDLE_SILENT: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        !port_global_enable && !$past(port_global_enable) |-> !BAUD_TICK_TX && !BAUD_TICK_RX)
        else $error("baud ticks while port disabled");

    AST_RESET_CODE_UNDIVIDED: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        divider_code == KCP_CODE_RESET |-> ratio == 9'h001)
        else $error("reset code does not pass clock undivided");

    sequence s_div_read;
        rd_state == KCP_RD_MEM && ar_addr == KCP_OFF_KERNEL_DIVIDER;
    endsequence

    AST_READ_CODE: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        s_div_read |=> RDATA == {28'h0000000, $past(divider_code)})
        else $error("prescaler read does not return the stored code");

endmodule

// file: verif/tb_serial_port_kernel_clock_prescaler.sv
// Testbench: register access and tick period checks for the kernel clock prescaler
`timescale 1ns/10ps
module tb_serial_port_kernel_clock_prescaler
    import kcp_pkg::*;
;
    logic        REF_CLK;
    logic        RST_N;
    logic [5:0]  AWADDR;
    logic [5:0]  ARADDR;
    logic        AWVALID;
    logic        WVALID;
    logic        BREADY;
    logic        ARVALID;
    logic        RREADY;
    logic [31:0] WDATA;
    logic [3:0]  WSTRB;
    logic        AWREADY;
    logic        WREADY;
    logic        BVALID;
    logic        ARREADY;
    logic        RVALID;
    logic        BAUD_TICK_TX;
    logic        BAUD_TICK_RX;
    logic [1:0]  BRESP;
    logic [1:0]  RRESP;
    logic [31:0] RDATA;
    logic [31:0] rd;
    logic [31:0] per;
    logic [1:0]  rsp;
    int          mismatches;
    int          n_compared;
    int          cycles;
    int          tick_diff;
    int          n;
    logic [8:0]  exp_ratio [16] = '{9'h001, 9'h002, 9'h004, 9'h006, 9'h008, 9'h00a, 9'h00c, 9'h010,
                                    9'h020, 9'h040, 9'h080, 9'h100, 9'h100, 9'h100, 9'h100, 9'h100};

    kcp_top kcp_top_i (
        .REF_CLK(REF_CLK), .RST_N(RST_N), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
        .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
        .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
        .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
        .BAUD_TICK_TX(BAUD_TICK_TX), .BAUD_TICK_RX(BAUD_TICK_RX)
    );

    initial begin
        REF_CLK = 1'b0;
        forever #25 REF_CLK = ~REF_CLK;
    end

    // ------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            mismatches++;
        end
    endtask

    task automatic give_verdict();
        if (mismatches == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    always @(posedge REF_CLK) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            mismatches++;
            give_verdict();
        end
    end

    // Both generators must see the same divided clock at all times
    always @(negedge REF_CLK) begin
        if (BAUD_TICK_RX !== BAUD_TICK_TX) tick_diff++;
    end

    // ------------------------------------------------------------
    // AXI4-Lite master; ready is looked at mid-cycle, where it is settled
    // ------------------------------------------------------------
    task automatic axi_write(input logic [5:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_ok, w_ok, aw_hs, w_hs, b_hs;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        b_hs = 1'b0;
        AWADDR <= a;
        WDATA <= d;
        WSTRB <= 4'hf;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(negedge REF_CLK);
            aw_hs = AWVALID && AWREADY;
            w_hs = WVALID && WREADY;
            @(posedge REF_CLK);
            if (aw_hs) begin
                AWVALID <= 1'b0;
                aw_ok = 1'b1;
            end
            if (w_hs) begin
                WVALID <= 1'b0;
                w_ok = 1'b1;
            end
        end
        while (!b_hs) begin
            @(negedge REF_CLK);
            b_hs = BVALID;
            r = BRESP;
            @(posedge REF_CLK);
        end
    endtask

    task automatic axi_read(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar_hs, r_hs;
        ar_hs = 1'b0;
        r_hs = 1'b0;
        ARADDR <= a;
        ARVALID <= 1'b1;
        while (!ar_hs) begin
            @(negedge REF_CLK);
            ar_hs = ARREADY;
            @(posedge REF_CLK);
        end
        ARVALID <= 1'b0;
        while (!r_hs) begin
            @(negedge REF_CLK);
            r_hs = RVALID;
            d = RDATA;
            r = RRESP;
            @(posedge REF_CLK);
        end
    endtask

    // Cycles between two successive ticks; caps at 600 so a dead divider cannot hang
    task automatic measure(output logic [31:0] p);
        int k;
        k = 0;
        p = 32'h0;
        do begin
            @(negedge REF_CLK);
            k++;
        end while (BAUD_TICK_TX !== 1'b1 && k < 600);
        do begin
            @(negedge REF_CLK);
            p++;
        end while (BAUD_TICK_TX !== 1'b1 && p < 600);
        @(posedge REF_CLK);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        RST_N = 1'b0;
        AWADDR = 6'h00;
        ARADDR = 6'h00;
        AWVALID = 1'b0;
        WVALID = 1'b0;
        ARVALID = 1'b0;
        WDATA = 32'h0;
        WSTRB = 4'h0;
        BREADY = 1'b1;
        RREADY = 1'b1;
        mismatches = 0;
        n_compared = 0;
        cycles = 0;
        tick_diff = 0;
        repeat (10) @(posedge REF_CLK);
        RST_N <= 1'b1;
        @(posedge REF_CLK);
        axi_read(KCP_OFF_KERNEL_DIVIDER, rd, rsp);
        check(rd, KCP_WORD_RESET);
        axi_write(KCP_OFF_CONTROL_ONE, 32'h1, rsp);
        measure(per);
        check(per, 32'h1);
        for (int c = 0; c < 16; c++) begin
            axi_write(KCP_OFF_CONTROL_ONE, 32'h0, rsp);
            axi_write(KCP_OFF_KERNEL_DIVIDER, 32'(c), rsp);
            check(32'(rsp), 32'(KCP_RESP_OKAY));
            axi_read(KCP_OFF_KERNEL_DIVIDER, rd, rsp);
            check(rd, 32'(c));
            axi_write(KCP_OFF_CONTROL_ONE, 32'h1, rsp);
            measure(per);
            check(per, 32'(exp_ratio[c]));
        end
        // Enabled with the largest ratio: a new code must be ignored
        axi_write(KCP_OFF_KERNEL_DIVIDER, 32'h1, rsp);
        axi_read(KCP_OFF_KERNEL_DIVIDER, rd, rsp);
        check(rd, 32'hf);
        measure(per);
        check(per, 32'h100);
        axi_write(KCP_OFF_CONTROL_ONE, 32'h0, rsp);
        n = 0;
        repeat (300) begin
            @(negedge REF_CLK);
            if (BAUD_TICK_TX === 1'b1) n++;
        end
        @(posedge REF_CLK);
        check(32'(n), 32'h0);
        axi_write(KCP_OFF_KERNEL_DIVIDER, 32'h1, rsp);
        axi_write(KCP_OFF_CONTROL_ONE, 32'h1, rsp);
        measure(per);
        check(per, 32'h2);
        // Map edges: plain storage, read-as-zero status, unmapped places
        axi_write(KCP_OFF_BAUD_RATE, 32'ha5a5_5a5a, rsp);
        axi_read(KCP_OFF_BAUD_RATE, rd, rsp);
        check(rd, 32'ha5a5_5a5a);
        axi_read(KCP_OFF_STATUS, rd, rsp);
        check(rd, 32'h0);
        axi_write(6'h3c, 32'h1, rsp);
        check(32'(rsp), 32'(KCP_RESP_SLVERR));
        axi_read(6'h30, rd, rsp);
        check(32'(rsp), 32'(KCP_RESP_SLVERR));
        check(rd, 32'h0);
        // Second reset in mid-run clears the code again
        RST_N <= 1'b0;
        repeat (3) @(posedge REF_CLK);
        RST_N <= 1'b1;
        @(posedge REF_CLK);
        axi_read(KCP_OFF_KERNEL_DIVIDER, rd, rsp);
        check(rd, KCP_WORD_RESET);
        check(32'(tick_diff), 32'h0);
        give_verdict();
    end
endmodule
